// file: logic/perf_event_pkg.sv
package perf_event_pkg;

   // ----------------------------------------------------------------
   // Event numbers.
   // ----------------------------------------------------------------
   localparam logic [7:0] EVT_SW_INCREMENT = 8'h00;
   localparam logic [7:0] EVT_DCACHE_ACCESS = 8'h04;
   localparam logic [7:0] EVT_DTLB_REFILL = 8'h05;
   localparam logic [7:0] EVT_DATA_READ = 8'h06;
   localparam logic [7:0] EVT_DATA_WRITE = 8'h07;
   localparam logic [7:0] EVT_INSTR_EXEC = 8'h08;
   localparam logic [7:0] EVT_EXC_TAKEN = 8'h09;
   localparam logic [7:0] EVT_EXC_RETURN = 8'h0A;
   localparam logic [7:0] EVT_CTXID_WRITE = 8'h0B;
   localparam logic [7:0] EVT_PC_CHANGE = 8'h0C;
   localparam logic [7:0] EVT_IMM_BRANCH = 8'h0D;
   localparam logic [7:0] EVT_PROC_RETURN = 8'h0E;
   localparam logic [7:0] EVT_UNALIGNED = 8'h0F;
   localparam logic [7:0] EVT_BRANCH_MISPRED = 8'h10;
   localparam logic [7:0] EVT_BRANCH_PREDICTABLE = 8'h12;
   localparam logic [7:0] EVT_IMPDEF_FIRST = 8'h40;

   // ----------------------------------------------------------------
   // Implementation-defined events provided here.
   // ----------------------------------------------------------------
   localparam logic [7:0] EVT_EXT_INPUT_CYCLES = 8'h40;
   localparam logic [7:0] EVT_IRQ_MASKED_CYCLES = 8'h41;
   localparam logic [7:0] EVT_EXT_INPUT_EDGES = 8'h42;

   // ----------------------------------------------------------------
   // Widths and reset values.
   // ----------------------------------------------------------------
   localparam int EVT_W = 8;
   localparam int LANES = 4;
   localparam int INC_W = 3;
   localparam logic [2:0] SYNC_RESET = 3'h0;

endpackage

// file: logic/perf_event_select_decode.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - 0x04 counts each data cache line access
// - 0x05 counts each data TLB walk
// - 0x06 counts retired passing data reads
// - 0x07 counts retired passing data writes
// - 0x08 counts all retired instructions
// - 0x09 counts one per exception taken
// - 0x0A counts passing exception returns
// - 0x0B counts passing context identifier writes
// - 0x0C counts passing software PC changes
// - 0x0D counts all immediate branches retired
// - 0x0E counts passing link-register procedure returns
// - PC writes not from link, writeback pop or post-indexed load are excluded from 0x0E
// - 0x0F counts passing unaligned accesses
// - 0x10 counts each misprediction flush
// - 0x12 counts predictable program flow changes
// - 0x11, 0x13-0x3F reserved; 0x40 up impdef
// - Impdef events count occurrences or cycles
// - External input counts asserted cycles
// - Event 0x41 counts cycles with both IRQ and FIQ masked
// - One occurrence advances counter by one
// - 0x00 counts software increment writes
// - Instruction events count retired instructions only; 0x04 and 0x05 also count speculative accesses

module perf_event_select_decode #(
   parameter int LANES = perf_event_pkg::LANES,
   parameter int INC_W = perf_event_pkg::INC_W
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] event_sel,
   input wire logic sw_increment,
   input wire logic [LANES-1:0] dcache_access,
   input wire logic [LANES-1:0] dtlb_walk,
   input wire logic [LANES-1:0] retire_valid,
   input wire logic [LANES-1:0] retire_cond_pass,
   input wire logic [LANES-1:0] retire_is_read,
   input wire logic [LANES-1:0] retire_is_write,
   input wire logic [LANES-1:0] retire_exc_return,
   input wire logic [LANES-1:0] retire_ctxid_write,
   input wire logic [LANES-1:0] retire_pc_write,
   input wire logic [LANES-1:0] retire_imm_branch,
   input wire logic [LANES-1:0] retire_pc_from_link,
   input wire logic [LANES-1:0] retire_pc_pop_writeback,
   input wire logic [LANES-1:0] retire_pc_postindex_load,
   input wire logic [LANES-1:0] retire_unaligned,
   input wire logic exception_taken,
   input wire logic mispredict_flush,
   input wire logic predictable_flow,
   input wire logic irq_mask,
   input wire logic fiq_mask,
   input wire logic ext_event,
   output logic [INC_W-1:0] count_increment,
   output logic count_enable,
   output logic event_reserved
);

   // ----------------------------------------------------------------
   // Elaboration check.
   // ----------------------------------------------------------------
   generate
      if (LANES < 1) begin : g_bad_lanes
         $error("At least one retirement lane is needed.");
      end
      if (INC_W < 1 || (1 << INC_W) <= LANES) begin : g_bad_width
         $error("Increment width cannot hold the lane count.");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------
   // Counts set bits so several occurrences in one cycle are all kept.
   function automatic logic [INC_W-1:0] popcount(input logic [LANES-1:0] v);
      logic [INC_W-1:0] n;
      n = '0;
      for (int i = 0; i < LANES; i++) begin
         n = n + INC_W'(v[i]);
      end
      return n;
   endfunction

   // Turns a single-cycle flag into a one-count increment.
   function automatic logic [INC_W-1:0] one(input logic v);
      return INC_W'(v);
   endfunction

   // ----------------------------------------------------------------
   // External and mask inputs.
   // ----------------------------------------------------------------
   logic ext_level;
   logic ext_rise;

   perf_event_sync u_ext_sync (
      .clk(clk),
      .srst(srst),
      .async_in(ext_event),
      .level(ext_level),
      .rise(ext_rise)
   );

   // ----------------------------------------------------------------
   // Qualified per-lane occurrences.
   // ----------------------------------------------------------------
   logic [LANES-1:0] passed;
   logic [LANES-1:0] read_lanes;
   logic [LANES-1:0] write_lanes;
   logic [LANES-1:0] exc_return_lanes;
   logic [LANES-1:0] ctxid_lanes;
   logic [LANES-1:0] pc_change_lanes;
   logic [LANES-1:0] imm_branch_lanes;
   logic [LANES-1:0] link_kind;
   logic [LANES-1:0] proc_return;
   logic [LANES-1:0] unaligned_lanes;

   // Only retired instructions count; condition-pass for most events.
   assign passed = retire_valid & retire_cond_pass;

   // Explicit data reads and writes; a swap instruction sets both.
   assign read_lanes = passed & retire_is_read;
   assign write_lanes = passed & retire_is_write;

   // Exception returns and context identifier writes must pass.
   assign exc_return_lanes = passed & retire_exc_return;
   assign ctxid_lanes = passed & retire_ctxid_write;

   // Any passing software write of the program counter.
   assign pc_change_lanes = passed & retire_pc_write;

   // Immediate branches count even when their condition fails.
   assign imm_branch_lanes = retire_valid & retire_imm_branch;

   // Link-register source, writeback pop or post-indexed load only.
   assign link_kind = retire_pc_from_link | retire_pc_pop_writeback
      | retire_pc_postindex_load;

   // A procedure return is a passing program counter write of link kind.
   assign proc_return = pc_change_lanes & link_kind;

   // Unaligned accesses, faulting or not, that passed their condition.
   assign unaligned_lanes = passed & retire_unaligned;

   // ----------------------------------------------------------------
   // Per-event amounts.
   // ----------------------------------------------------------------
   logic [INC_W-1:0] amt_swinc;
   logic [INC_W-1:0] amt_exc_taken;
   logic [INC_W-1:0] amt_mispred;
   logic [INC_W-1:0] amt_predictable;
   logic [INC_W-1:0] amt_dcache;
   logic [INC_W-1:0] amt_dtlb;
   logic [INC_W-1:0] amt_read;
   logic [INC_W-1:0] amt_write;
   logic [INC_W-1:0] amt_instr;
   logic [INC_W-1:0] amt_exc_return;
   logic [INC_W-1:0] amt_ctxid;
   logic [INC_W-1:0] amt_pc_change;
   logic [INC_W-1:0] amt_imm_branch;
   logic [INC_W-1:0] amt_proc_return;
   logic [INC_W-1:0] amt_unaligned;
   logic [INC_W-1:0] amt_ext_cycles;
   logic [INC_W-1:0] amt_ext_edges;
   logic [INC_W-1:0] amt_mask_cycles;

   // A software increment write is a step of one.
   assign amt_swinc = one(sw_increment);

   // Single-cycle pipeline pulses become a step of one each.
   assign amt_exc_taken = one(exception_taken);
   assign amt_mispred = one(mispredict_flush);
   assign amt_predictable = one(predictable_flow);

   // Memory system occurrences, speculative ones included.
   assign amt_dcache = popcount(dcache_access);
   assign amt_dtlb = popcount(dtlb_walk);

   // Data transfers and retired instructions add one per lane.
   assign amt_read = popcount(read_lanes);
   assign amt_write = popcount(write_lanes);
   assign amt_instr = popcount(retire_valid);

   // Status-changing instructions add one per qualifying lane.
   assign amt_exc_return = popcount(exc_return_lanes);
   assign amt_ctxid = popcount(ctxid_lanes);
   assign amt_pc_change = popcount(pc_change_lanes);

   // Branches, returns and unaligned accesses add one per lane.
   assign amt_imm_branch = popcount(imm_branch_lanes);
   assign amt_proc_return = popcount(proc_return);
   assign amt_unaligned = popcount(unaligned_lanes);

   // Implementation-defined events: external input and interrupt masks.
   assign amt_ext_cycles = one(ext_level);
   assign amt_ext_edges = one(ext_rise);
   assign amt_mask_cycles = one(irq_mask & fiq_mask);

   // ----------------------------------------------------------------
   // Event select decode.
   // ----------------------------------------------------------------
   logic [INC_W-1:0] next_increment;
   logic next_reserved;

   // Each selection collapses to one increment value per cycle.
   always_comb begin
      next_increment = '0;
      next_reserved = 1'b0;
      unique case (event_sel)
         perf_event_pkg::EVT_SW_INCREMENT: begin
            next_increment = amt_swinc;
         end
         perf_event_pkg::EVT_DCACHE_ACCESS: begin
            next_increment = amt_dcache;
         end
         perf_event_pkg::EVT_DTLB_REFILL: begin
            next_increment = amt_dtlb;
         end
         perf_event_pkg::EVT_DATA_READ: begin
            next_increment = amt_read;
         end
         perf_event_pkg::EVT_DATA_WRITE: begin
            next_increment = amt_write;
         end
         perf_event_pkg::EVT_INSTR_EXEC: begin
            next_increment = amt_instr;
         end
         perf_event_pkg::EVT_EXC_TAKEN: begin
            next_increment = amt_exc_taken;
         end
         perf_event_pkg::EVT_EXC_RETURN: begin
            next_increment = amt_exc_return;
         end
         perf_event_pkg::EVT_CTXID_WRITE: begin
            next_increment = amt_ctxid;
         end
         perf_event_pkg::EVT_PC_CHANGE: begin
            next_increment = amt_pc_change;
         end
         perf_event_pkg::EVT_IMM_BRANCH: begin
            next_increment = amt_imm_branch;
         end
         perf_event_pkg::EVT_PROC_RETURN: begin
            next_increment = amt_proc_return;
         end
         perf_event_pkg::EVT_UNALIGNED: begin
            next_increment = amt_unaligned;
         end
         perf_event_pkg::EVT_BRANCH_MISPRED: begin
            next_increment = amt_mispred;
         end
         perf_event_pkg::EVT_BRANCH_PREDICTABLE: begin
            next_increment = amt_predictable;
         end
         perf_event_pkg::EVT_EXT_INPUT_CYCLES: begin
            next_increment = amt_ext_cycles;
         end
         perf_event_pkg::EVT_IRQ_MASKED_CYCLES: begin
            next_increment = amt_mask_cycles;
         end
         perf_event_pkg::EVT_EXT_INPUT_EDGES: begin
            next_increment = amt_ext_edges;
         end
         default: begin
            // Reserved and unimplemented codes never count.
            next_reserved = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registered outputs to the counter.
   // ----------------------------------------------------------------
   // Amount to add this cycle, with every simultaneous occurrence kept.
   always_ff @(posedge clk) begin
      if (srst) begin
         count_increment <= '0;
      end else begin
         count_increment <= next_increment;
      end
   end

   // Enable means a nonzero step, so reserved codes never enable.
   always_ff @(posedge clk) begin
      if (srst) begin
         count_enable <= 1'b0;
      end else begin
         count_enable <= (next_increment != '0);
      end
   end

   // Flags a selection that this decoder does not implement.
   always_ff @(posedge clk) begin
      if (srst) begin
         event_reserved <= 1'b0;
      end else begin
         event_reserved <= next_reserved;
      end
   end

endmodule

`default_nettype wire

// file: logic/perf_event_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Three-stage synchroniser for an external event level.
// ----------------------------------------------------------------
module perf_event_sync (
   input wire logic clk,
   input wire logic srst,
   input wire logic async_in,
   output logic level,
   output logic rise
);

   logic [2:0] stage;

   // Only stages two and three are compared; stage one feeds stage two alone.
   always_ff @(posedge clk) begin
      if (srst) begin
         stage <= perf_event_pkg::SYNC_RESET;
         level <= 1'b0;
         rise <= 1'b0;
      end else begin
         stage <= {stage[1:0], async_in};
         if (stage[1] == stage[2]) begin
            level <= stage[2];
            rise <= stage[2] & ~level;
         end else begin
            rise <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// file: verif/perf_event_select_decode_props.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port checker for the event select decoder.
// ----------------------------------------------------------------
module perf_event_select_decode_chk #(
   parameter int LANES = 4,
   parameter int INC_W = 3
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] event_sel,
   input wire logic sw_increment,
   input wire logic [LANES-1:0] retire_valid,
   input wire logic exception_taken,
   input wire logic mispredict_flush,
   input wire logic irq_mask,
   input wire logic fiq_mask,
   input wire logic [INC_W-1:0] count_increment,
   input wire logic count_enable,
   input wire logic event_reserved
);
   // All checks run on the core clock and pause while reset is high.
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_enable_tracks_amount: assert property (count_enable == (count_increment != '0))
      else $error("enable disagrees with increment amount");
   a_reserved_stays_silent: assert property (event_reserved |-> count_increment == '0)
      else $error("reserved selection produced an increment");
   a_reserved_range_flag: assert property (event_sel inside {8'h11, [8'h13:8'h3F]}
      |=> event_reserved)
      else $error("reserved code not flagged");
   a_impdef_not_reserved: assert property (event_sel inside {[8'h40:8'h42]}
      |=> !event_reserved)
      else $error("provided implementation event flagged reserved");
   a_swinc_counts_write: assert property (event_sel == 8'h00
      |=> count_increment == INC_W'($past(sw_increment)))
      else $error("software increment count wrong");
   a_exception_one_each: assert property (event_sel == 8'h09
      |=> count_increment == INC_W'($past(exception_taken)))
      else $error("exception count wrong");
   a_flush_one_each: assert property (event_sel == 8'h10
      |=> count_increment == INC_W'($past(mispredict_flush)))
      else $error("misprediction flush count wrong");
   a_instr_all_lanes: assert property (event_sel == 8'h08
      |=> count_increment == INC_W'($countones($past(retire_valid))))
      else $error("instruction count wrong");
   a_mask_cycle_count: assert property (event_sel == 8'h41
      |=> count_increment == INC_W'($past(irq_mask & fiq_mask)))
      else $error("masked cycle count wrong");
endmodule

bind perf_event_select_decode perf_event_select_decode_chk #(.LANES(LANES), .INC_W(INC_W)) chk_u (
   .clk(clk), .srst(srst), .event_sel(event_sel), .sw_increment(sw_increment),
   .retire_valid(retire_valid), .exception_taken(exception_taken),
   .mispredict_flush(mispredict_flush), .irq_mask(irq_mask), .fiq_mask(fiq_mask),
   .count_increment(count_increment), .count_enable(count_enable),
   .event_reserved(event_reserved));

`default_nettype wire

// file: verif/pipe_event_source.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Pipeline and memory system event source model.
// ----------------------------------------------------------------
module pipe_event_source #(
   parameter int LANES = 4
) (
   input wire logic clk,
   output logic [14*LANES-1:0] lane_flags,
   output logic [2:0] pulses
);
   logic [14*LANES-1:0] next_flags;

   initial begin
      lane_flags = '0;
      pulses = '0;
   end

   // New random events each falling edge; attributes toggle on idle lanes, but link kinds are cleared on lanes with no PC write.
   always @(negedge clk) begin
      next_flags = (14*LANES)'({$urandom, $urandom});
      for (int i = 0; i < LANES; i++) begin
         if (!next_flags[8*LANES+i]) begin
            next_flags[10*LANES+i] = 1'b0;
            next_flags[11*LANES+i] = 1'b0;
            next_flags[12*LANES+i] = 1'b0;
         end
      end
      lane_flags <= next_flags;
      pulses <= 3'($urandom);
   end
endmodule

`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int L = 4;
   localparam int INC_W = 3;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] event_sel = 8'h00;
   logic sw_increment = 1'b0;
   logic irq_mask = 1'b0;
   logic fiq_mask = 1'b0;
   logic ext_event = 1'b0;
   logic [14*L-1:0] lv;
   logic [2:0] pul;
   logic [INC_W-1:0] count_increment;
   logic count_enable;
   logic event_reserved;
   int miscompares = 0;
   int compares = 0;
   int exp_inc = 0;
   logic exp_res = 1'b0;
   logic [4:0] ext_hist = '0;

   // ----------------------------------------------------------------
   // Clock, partner and design.
   // ----------------------------------------------------------------
   initial begin
      forever #2 clk = ~clk;
   end

   pipe_event_source #(.LANES(L)) src_u (.clk(clk), .lane_flags(lv), .pulses(pul));

   perf_event_select_decode #(.LANES(L), .INC_W(INC_W)) dut_u (
      .clk(clk), .srst(srst), .event_sel(event_sel), .sw_increment(sw_increment),
      .dcache_access(lv[0+:L]), .dtlb_walk(lv[L+:L]), .retire_valid(lv[2*L+:L]),
      .retire_cond_pass(lv[3*L+:L]), .retire_is_read(lv[4*L+:L]),
      .retire_is_write(lv[5*L+:L]), .retire_exc_return(lv[6*L+:L]),
      .retire_ctxid_write(lv[7*L+:L]), .retire_pc_write(lv[8*L+:L]),
      .retire_imm_branch(lv[9*L+:L]), .retire_pc_from_link(lv[10*L+:L]),
      .retire_pc_pop_writeback(lv[11*L+:L]), .retire_pc_postindex_load(lv[12*L+:L]),
      .retire_unaligned(lv[13*L+:L]), .exception_taken(pul[0]),
      .mispredict_flush(pul[1]), .predictable_flow(pul[2]), .irq_mask(irq_mask),
      .fiq_mask(fiq_mask), .ext_event(ext_event), .count_increment(count_increment),
      .count_enable(count_enable), .event_reserved(event_reserved));

   // ----------------------------------------------------------------
   // Reference model.
   // ----------------------------------------------------------------
   function automatic bit f(input int k, input int i);
      return lv[k*L+i];
   endfunction

   // Sums every qualifying occurrence of the selected event this cycle.
   function automatic int expect_inc(input logic [7:0] s);
      int n;
      bit v;
      bit vp;
      n = 0;
      for (int i = 0; i < L; i++) begin
         v = f(2, i);
         vp = v & f(3, i);
         case (s)
            8'h04: n += f(0, i);
            8'h05: n += f(1, i);
            8'h06: n += vp & f(4, i);
            8'h07: n += vp & f(5, i);
            8'h08: n += v;
            8'h0A: n += vp & f(6, i);
            8'h0B: n += vp & f(7, i);
            8'h0C: n += vp & f(8, i);
            8'h0D: n += v & f(9, i);
            8'h0E: n += vp & f(8, i) & (f(10, i) | f(11, i) | f(12, i));
            8'h0F: n += vp & f(13, i);
            default: n += 0;
         endcase
      end
      case (s)
         8'h00: n = sw_increment;
         8'h09: n = pul[0];
         8'h10: n = pul[1];
         8'h12: n = pul[2];
         8'h40: n = ext_hist[3];
         8'h41: n = irq_mask & fiq_mask;
         8'h42: n = ext_hist[3] & ~ext_hist[4];
         default: n += 0;
      endcase
      return n;
   endfunction

   // Expectations use inputs at the sampling edge; the external pin is seen four edges late.
   always @(posedge clk) begin
      if (srst) begin
         exp_inc <= 0;
         exp_res <= 1'b0;
         ext_hist <= '0;
      end else begin
         exp_inc <= expect_inc(event_sel);
         exp_res <= !(event_sel inside {8'h00, [8'h04:8'h10], 8'h12, [8'h40:8'h42]});
         ext_hist <= {ext_hist[3:0], ext_event};
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Stimulus: every event code, random traffic, two external levels per code, a mid-run reset.
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(62202));
      repeat (8) @(negedge clk);
      srst = 1'b0;
      for (int c = 0; c < 256; c++) begin
         for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            check(8'(count_increment), 8'(exp_inc));
            check(8'(count_enable), 8'(exp_inc != 0));
            check(8'(event_reserved), 8'(exp_res));
            srst = (c == 128) && (k < 4);
            if (k % 6 == 0) begin
               ext_event = 1'($urandom);
            end
            event_sel = 8'(c);
            sw_increment = 1'($urandom);
            irq_mask = 1'($urandom);
            fiq_mask = 1'($urandom);
         end
      end
      finish_test();
   end

   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      finish_test();
   end
endmodule

`default_nettype wire
